// ---- src/hvw_map.svh ----
// constants for the high-voltage wake pin and interrupt control block
// Operation
// - wake pin defaults to pulled-down output, driver raises wake bus high
// - first config bit 4 asserts the wake output driver
// - wake output follows a config write only after the 10 us interface transfer
// - enabled-at-reset monoflop turns the wake driver off after 1.3 s
// - wake sourcing over 100 mA for 400 us sets monitor bit 0, interrupts
// - thermal shutdown kills wake driver; second config bit 3 re-enables it
// - second config bit 4 selects I/O mode; any pin edge interrupts
// - monitor bit 7 shows the live wake pin comparator level
// - core enable bit 16 lets six sources drive the interrupt line
// - every interrupt event copies the status snapshot into the data register
// - command bit 0 reads busy during the copy, clears after 10 us
// - first config bit 2 enables low-supply flag seen at monitor bit 3
// - low-supply flag clears only on supply below 2.1 V or disable
// - bus pin low drawing over 100 mA for 20 us gives short interrupt
// - bus pin shorted to ground reads back low while driven high
// - wake pin shorted to battery reads high at monitor bit 7
// - open-circuit resistor with driver off: bit 7 low loaded, high open
// - snapshot bits: 5 supply, 4 wake edge, 3 thermal, 2/1/0 shorts
// - bus short flags clear when the snapshot is read
`ifndef HVW_MAP_SVH
`define HVW_MAP_SVH

// register byte offsets
`define HVW_OFS_COMMAND     5'h00
`define HVW_OFS_DATA        5'h04
`define HVW_OFS_CFG_FIRST   5'h08
`define HVW_OFS_CFG_SECOND  5'h0C
`define HVW_OFS_MONITOR     5'h10
`define HVW_OFS_IRQ_ENABLE  5'h14

// command register fields
`define HVW_CMD_BUSY        0
`define HVW_CMD_OK          1
`define HVW_CMD_SNAP        2

// first config fields
`define HVW_CF1_LVF_EN      2
`define HVW_CF1_PSM_EN      3
`define HVW_CF1_WAKE_DRV    4

// second config fields
`define HVW_CF2_MONO_DIS    1
`define HVW_CF2_REENABLE    3
`define HVW_CF2_IO_MODE     4
`define HVW_CF2_OC_EN       5

// monitor fields
`define HVW_MON_WAKE_SC     0
`define HVW_MON_AUX_RB      1
`define HVW_MON_LIN_RB      2
`define HVW_MON_LVF         3
`define HVW_MON_THERMAL     4
`define HVW_MON_PSM         5
`define HVW_MON_WAKE_PIN    7

// snapshot fields
`define HVW_STA_WAKE_SC     0
`define HVW_STA_AUX_SC      1
`define HVW_STA_LIN_SC      2
`define HVW_STA_THERMAL     3
`define HVW_STA_WAKE_REQ    4
`define HVW_STA_PSM         5

// core interrupt enable field
`define HVW_IRQ_EN_BIT      16

// reset values
`define HVW_RST_CFG         8'h00
`define HVW_RST_IRQ_EN      32'h0000_0000

// timing: clock rate and printed times
`define HVW_CLK_MHZ         40
`define HVW_CLK_KHZ         40000
`define HVW_XFER_US         10
`define HVW_XFER_CYC        (`HVW_XFER_US * `HVW_CLK_MHZ)
`define HVW_BUS_SC_US       20
`define HVW_BUS_SC_CYC      (`HVW_BUS_SC_US * `HVW_CLK_MHZ)
`define HVW_WAKE_SC_US      400
`define HVW_WAKE_SC_CYC     (`HVW_WAKE_SC_US * `HVW_CLK_MHZ)
`define HVW_MONO_MS         1300
`define HVW_MONO_CYC        (`HVW_MONO_MS * `HVW_CLK_KHZ)

`endif

// ---- src/hvw_pkg.sv ----
// types for the high-voltage wake pin and interrupt control block
package hvw_pkg;
	// serial high-voltage interface transfer engine
	typedef enum logic [0:0] {
		HVW_IDLE = 1'b0,
		HVW_XFER = 1'b1
	} hvw_xfer_e;
	typedef logic [7:0] hvw_byte_t;
endpackage

// ---- src/hvw_sync.sv ----
// three-flop input synchroniser, level accepted when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module hvw_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             arst_n,
	// asynchronous levels in, filtered levels out
	input  wire logic [WIDTH-1:0] async_in,
	output var  logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] take;

	// only stage two reads stage one
	assign take = ~(s2_reg ^ s3_reg);

	////////////////////////////////////////////////////////////////////////
	// stage chain, output moves per bit once the last two stages agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_reg   <= '0;
			s2_reg   <= '0;
			s3_reg   <= '0;
			sync_out <= '0;
		end else begin
			s1_reg   <= async_in;
			s2_reg   <= s1_reg;
			s3_reg   <= s2_reg;
			sync_out <= (sync_out & ~take) | (s3_reg & take);
		end
	end
endmodule // hvw_sync
`default_nettype wire

// ---- src/hvw_hold.sv ----
// persistence filter: pulses once a condition has held for CYC cycles
`timescale 1ns/1ps
`default_nettype none
module hvw_hold #(
	parameter int CYC = 800
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// condition and one-cycle hit
	input  wire logic cond,
	output var  logic hit
);
	localparam int W = $clog2(CYC + 1);
	localparam logic [W-1:0] LAST = W'(CYC - 1);
	logic [W-1:0] cnt_reg;
	logic         reach;

	// a break in the condition restarts the count, so only steady faults fire
	assign reach = cond && (cnt_reg == LAST);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_reg <= '0;
			hit     <= 1'b0;
		end else begin
			cnt_reg <= !cond ? '0 : (cnt_reg == W'(CYC) ? cnt_reg : cnt_reg + W'(1));
			hit     <= reach;
		end
	end
endmodule // hvw_hold
`default_nettype wire

// ---- src/hvw_top.sv ----
// high-voltage wake pin, interrupt snapshot and diagnostics with avalon-mm slave
//
// Decided for this implementation: the Avalon-MM register port and the register addresses.
`include "hvw_map.svh"
`timescale 1ns/1ps
`default_nettype none
module hvw_top #(
	parameter int XFER_CYC    = `HVW_XFER_CYC,
	parameter int BUS_SC_CYC  = `HVW_BUS_SC_CYC,
	parameter int WAKE_SC_CYC = `HVW_WAKE_SC_CYC,
	parameter int MONO_CYC    = `HVW_MONO_CYC
) (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        arst_n,
	// avalon-mm slave
	input  wire logic [2:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output var  logic [31:0] avs_readdata,
	output var  logic        avs_waitrequest,
	// wake pin
	input  wire logic        wake_pin_in,
	output var  logic        wake_pin_out,
	output var  logic        wake_pin_oe,
	output var  logic        open_circuit_check_en,
	// analog fault and supply comparators
	input  wire logic        wake_overcurrent,
	input  wire logic        lin_overcurrent,
	input  wire logic        aux_overcurrent,
	input  wire logic        lin_readback,
	input  wire logic        aux_hv_bus_pin_readback,
	input  wire logic        thermal_shutdown,
	input  wire logic        regulated_digital_supply_low,
	input  wire logic        supply_monitor_low,
	// bus driver state from same-clock logic
	input  wire logic        lin_driving_low,
	input  wire logic        aux_driving_low,
	// interrupt to core
	output var  logic        hv_interrupt_line
);
	localparam int MW = $clog2(MONO_CYC + 1);
	localparam int XW = $clog2(XFER_CYC + 1);
	localparam logic [MW-1:0] MONO_LAST = MW'(MONO_CYC - 1);
	localparam logic [XW-1:0] XFER_LAST = XW'(XFER_CYC - 1);

	////////////////////////////////////////////////////////////////////////
	// declarations
	hvw_pkg::hvw_xfer_e state_reg, state_next;
	logic [XW-1:0]      xcnt_reg;
	logic               kind_snap_reg, snap_pend_reg, cfg_pend_reg;
	hvw_pkg::hvw_byte_t cfg1_sw_reg, cfg2_sw_reg, cfg1_app_reg, cfg2_app_reg, data_reg;
	logic               ok_reg, irq_en_reg, thermal_off_reg, mono_exp_reg;
	logic [4:0]         sta_lat_reg;
	logic [MW-1:0]      mono_cnt_reg;
	logic               lvf_reg, lvf_en_d_reg, psm_d_reg, wake_s_d_reg;
	logic [8:0]         sync_q;
	logic               wake_s, wake_oc_s, lin_oc_s, aux_oc_s, lin_rb_s;
	logic               aux_rb_s, thermal_s, dvdd_low_s, vdd_low_s;
	logic               wake_sc_hit, lin_sc_hit, aux_sc_hit;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers and fault persistence filters
	hvw_sync #(.WIDTH(9)) u_sync (
		.clk      (clk),
		.arst_n   (arst_n),
		.async_in ({supply_monitor_low, regulated_digital_supply_low, thermal_shutdown,
			aux_hv_bus_pin_readback, lin_readback, aux_overcurrent, lin_overcurrent,
			wake_overcurrent, wake_pin_in}),
		.sync_out (sync_q)
	);
	assign {vdd_low_s, dvdd_low_s, thermal_s, aux_rb_s, lin_rb_s, aux_oc_s, lin_oc_s,
		wake_oc_s, wake_s} = sync_q;

	hvw_hold #(.CYC(WAKE_SC_CYC)) u_wake_sc (
		.clk    (clk),
		.arst_n (arst_n),
		.cond   (wake_oc_s && wake_pin_oe),
		.hit    (wake_sc_hit)
	);
	hvw_hold #(.CYC(BUS_SC_CYC)) u_lin_sc (
		.clk    (clk),
		.arst_n (arst_n),
		.cond   (lin_oc_s && lin_driving_low),
		.hit    (lin_sc_hit)
	);
	hvw_hold #(.CYC(BUS_SC_CYC)) u_aux_sc (
		.clk    (clk),
		.arst_n (arst_n),
		.cond   (aux_oc_s && aux_driving_low),
		.hit    (aux_sc_hit)
	);

	////////////////////////////////////////////////////////////////////////
	// bus decode
	logic [4:0]  byte_addr;
	logic        req, wr_acc, wr_cmd, wr_cfg1, wr_cfg2, wr_irq;
	logic [31:0] rd_mux;
	assign byte_addr = {avs_address, 2'b00};
	assign req       = avs_read || avs_write;
	// a write lands only on the edge where waitrequest is seen low
	assign wr_acc    = avs_write && !avs_waitrequest;
	assign wr_cmd    = wr_acc && avs_byteenable[0] && byte_addr == `HVW_OFS_COMMAND;
	assign wr_cfg1   = wr_acc && avs_byteenable[0] && byte_addr == `HVW_OFS_CFG_FIRST;
	assign wr_cfg2   = wr_acc && avs_byteenable[0] && byte_addr == `HVW_OFS_CFG_SECOND;
	assign wr_irq    = wr_acc && avs_byteenable[2] && byte_addr == `HVW_OFS_IRQ_ENABLE;

	////////////////////////////////////////////////////////////////////////
	// live monitor, snapshot and event sources
	logic               psm_live, io_mode, mono_dis, new_event, xfer_done;
	logic               snap_done, cfg_done, reenable, drive_next;
	logic [4:0]         sta_set;
	hvw_pkg::hvw_byte_t monitor, snapshot;
	assign io_mode  = cfg2_app_reg[`HVW_CF2_IO_MODE];
	assign mono_dis = cfg2_app_reg[`HVW_CF2_MONO_DIS];
	assign psm_live = vdd_low_s && cfg1_app_reg[`HVW_CF1_PSM_EN];
	// edge in io mode raises wake request
	assign sta_set[`HVW_STA_WAKE_REQ] = io_mode && (wake_s != wake_s_d_reg);
	assign sta_set[`HVW_STA_THERMAL]  = thermal_s;
	assign sta_set[`HVW_STA_LIN_SC]   = lin_sc_hit;
	assign sta_set[`HVW_STA_AUX_SC]   = aux_sc_hit;
	assign sta_set[`HVW_STA_WAKE_SC]  = wake_sc_hit;
	// six sources, edge of each is one event
	assign new_event = |(sta_set & ~sta_lat_reg) || (psm_live && !psm_d_reg);
	assign snapshot  = {2'b00, psm_live, sta_lat_reg};
	// bus pin readbacks reach the monitor
	// live pin level, also the readback
	assign monitor   = {wake_s, 1'b0, psm_live, thermal_off_reg, lvf_reg, lin_rb_s, aux_rb_s,
		sta_lat_reg[`HVW_STA_WAKE_SC]};
	assign xfer_done = state_reg == hvw_pkg::HVW_XFER && xcnt_reg == XFER_LAST;
	assign snap_done = xfer_done && kind_snap_reg;
	assign cfg_done  = xfer_done && !kind_snap_reg;
	// re-enable is a one-shot command carried by the transfer
	assign reenable  = cfg_done && cfg2_sw_reg[`HVW_CF2_REENABLE];
	// driver on only in output mode with no protection tripped
	assign drive_next = cfg1_app_reg[`HVW_CF1_WAKE_DRV] && !io_mode && !thermal_off_reg && !mono_exp_reg;

	// register read mux, unmapped reads as zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (byte_addr)
			`HVW_OFS_COMMAND:    rd_mux[1:0] = {ok_reg, state_reg == hvw_pkg::HVW_XFER};
			`HVW_OFS_DATA:       rd_mux[7:0] = data_reg;
			`HVW_OFS_CFG_FIRST:  rd_mux[7:0] = cfg1_sw_reg;
			`HVW_OFS_CFG_SECOND: rd_mux[7:0] = cfg2_sw_reg;
			`HVW_OFS_MONITOR:    rd_mux[7:0] = monitor;
			`HVW_OFS_IRQ_ENABLE: rd_mux[`HVW_IRQ_EN_BIT] = irq_en_reg;
			default:             rd_mux = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// avalon handshake: one wait cycle, then a single acknowledge cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0000_0000;
		end else begin
			avs_waitrequest <= !(req && avs_waitrequest);
			if (avs_read && avs_waitrequest)
				avs_readdata <= rd_mux;
		end
	end

	// software-side configuration and interrupt enable
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg1_sw_reg <= `HVW_RST_CFG;
			cfg2_sw_reg <= `HVW_RST_CFG;
			irq_en_reg  <= 1'b0;
		end else begin
			if (wr_cfg1)
				cfg1_sw_reg <= avs_writedata[7:0];
			if (wr_cfg2)
				cfg2_sw_reg <= avs_writedata[7:0];
			else if (reenable)
				cfg2_sw_reg[`HVW_CF2_REENABLE] <= 1'b0;
			if (wr_irq)
				irq_en_reg <= avs_writedata[`HVW_IRQ_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial interface engine: every crossing to the high-voltage side costs XFER_CYC
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			hvw_pkg::HVW_IDLE: if (snap_pend_reg || cfg_pend_reg) state_next = hvw_pkg::HVW_XFER;
			hvw_pkg::HVW_XFER: if (xfer_done) state_next = hvw_pkg::HVW_IDLE;
			default:           state_next = hvw_pkg::HVW_IDLE;
		endcase
	end

	logic start;
	assign start = state_reg == hvw_pkg::HVW_IDLE && state_next == hvw_pkg::HVW_XFER;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg     <= hvw_pkg::HVW_IDLE;
			xcnt_reg      <= '0;
			kind_snap_reg <= 1'b0;
			snap_pend_reg <= 1'b0;
			cfg_pend_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			xcnt_reg  <= (state_reg == hvw_pkg::HVW_XFER && !xfer_done) ? xcnt_reg + XW'(1) : '0;
			if (start)
				kind_snap_reg <= snap_pend_reg;
			// events queue a snapshot, new requests win over the take
			snap_pend_reg <= new_event || (wr_cmd && avs_writedata[`HVW_CMD_SNAP]) ||
				(snap_pend_reg && !(start && snap_pend_reg));
			// config writes wait for the link
			cfg_pend_reg  <= wr_cfg1 || wr_cfg2 || (cfg_pend_reg && !(start && !snap_pend_reg));
		end
	end

	// data and success flag settle when the copy ends
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_reg     <= 8'h00;
			ok_reg       <= 1'b0;
			cfg1_app_reg <= `HVW_RST_CFG;
			cfg2_app_reg <= `HVW_RST_CFG;
		end else begin
			if (start && snap_pend_reg)
				ok_reg <= 1'b0;
			else if (snap_done)
				ok_reg <= 1'b1;
			if (snap_done)
				data_reg <= snapshot;
			// applied copy updates only at transfer end
			if (cfg_done) begin
				cfg1_app_reg <= cfg1_sw_reg;
				cfg2_app_reg <= cfg2_sw_reg;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// latched status, set wins over the read clear
	// reading the snapshot clears the short flags
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sta_lat_reg  <= 5'h00;
			psm_d_reg    <= 1'b0;
			wake_s_d_reg <= 1'b0;
		end else begin
			sta_lat_reg  <= (sta_lat_reg & {5{!snap_done}}) | sta_set;
			psm_d_reg    <= psm_live;
			wake_s_d_reg <= wake_s;
		end
	end

	// interrupt line gated by core enable
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			hv_interrupt_line <= 1'b0;
		else
			hv_interrupt_line <= irq_en_reg && ((|sta_lat_reg) || psm_live);
	end

	////////////////////////////////////////////////////////////////////////
	// thermal trip holds the driver off until re-enabled
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			thermal_off_reg <= 1'b0;
		else
			thermal_off_reg <= thermal_s || (thermal_off_reg && !reenable);
	end

	// monoflop counts driver-on time, off after 1.3 s unless disabled
	// with the monoflop disabled software owns the 1.3 s limit
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			mono_cnt_reg <= '0;
			mono_exp_reg <= 1'b0;
		end else begin
			mono_cnt_reg <= (wake_pin_oe && mono_cnt_reg != MONO_LAST) ? mono_cnt_reg + MW'(1) : '0;
			if (!cfg1_app_reg[`HVW_CF1_WAKE_DRV])
				mono_exp_reg <= 1'b0;
			else if (wake_pin_oe && !mono_dis && mono_cnt_reg == MONO_LAST)
				mono_exp_reg <= 1'b1;
		end
	end

	// high-side driver pulls the bus high, pull-down otherwise
	// diagnostic resistor only while the driver is off
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wake_pin_oe           <= 1'b0;
			wake_pin_out          <= 1'b0;
			open_circuit_check_en <= 1'b0;
		end else begin
			wake_pin_oe           <= drive_next;
			wake_pin_out          <= drive_next;
			open_circuit_check_en <= cfg2_app_reg[`HVW_CF2_OC_EN] && !drive_next;
		end
	end

	// flag sets on enable and clears on low supply or disable
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			lvf_reg      <= 1'b0;
			lvf_en_d_reg <= 1'b0;
		end else begin
			lvf_en_d_reg <= cfg1_app_reg[`HVW_CF1_LVF_EN];
			if (!cfg1_app_reg[`HVW_CF1_LVF_EN] || dvdd_low_s)
				lvf_reg <= 1'b0;
			else if (!lvf_en_d_reg)
				lvf_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	property p_thermal_off;
		@(posedge clk) disable iff (!arst_n) thermal_off_reg |=> !wake_pin_oe;
	endproperty
	a_thermal_off: assert property (p_thermal_off) else $error("driver on after thermal trip");
	property p_mono_off;
		@(posedge clk) disable iff (!arst_n)
			(wake_pin_oe && !mono_dis && mono_cnt_reg == MONO_LAST) |=> ##1 !wake_pin_oe;
	endproperty
	a_mono_off: assert property (p_mono_off) else $error("monoflop did not stop driver");
	property p_snap_start;
		@(posedge clk) disable iff (!arst_n)
			(new_event && state_reg == hvw_pkg::HVW_IDLE && !cfg_pend_reg) |=> ##1 (state_reg == hvw_pkg::HVW_XFER);
	endproperty
	a_snap_start: assert property (p_snap_start) else $error("event did not start copy");
	property p_busy_end;
		@(posedge clk) disable iff (!arst_n)
			snap_done |=> ok_reg && state_reg == hvw_pkg::HVW_IDLE && data_reg == $past(snapshot);
	endproperty
	a_busy_end: assert property (p_busy_end) else $error("snapshot not valid at busy clear");
	property p_irq_on;
		@(posedge clk) disable iff (!arst_n) (irq_en_reg && (|sta_lat_reg)) |=> hv_interrupt_line;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("interrupt line missed a source");
	property p_irq_gate;
		@(posedge clk) disable iff (!arst_n) !irq_en_reg |=> !hv_interrupt_line;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt line without enable");
	property p_lvf_clear;
		@(posedge clk) disable iff (!arst_n) dvdd_low_s |=> !lvf_reg;
	endproperty
	a_lvf_clear: assert property (p_lvf_clear) else $error("low-supply flag survived low supply");
	property p_edge_latch;
		@(posedge clk) disable iff (!arst_n) (io_mode && wake_s != wake_s_d_reg) |=> sta_lat_reg[`HVW_STA_WAKE_REQ];
	endproperty
	a_edge_latch: assert property (p_edge_latch) else $error("io edge not latched");
	property p_wake_sc;
		@(posedge clk) disable iff (!arst_n) wake_sc_hit |=> monitor[`HVW_MON_WAKE_SC];
	endproperty
	a_wake_sc: assert property (p_wake_sc) else $error("wake short not flagged");
	property p_read_clear;
		@(posedge clk) disable iff (!arst_n)
			(snap_done && !sta_set[`HVW_STA_LIN_SC] && !sta_set[`HVW_STA_AUX_SC]) |=> !sta_lat_reg[2] && !sta_lat_reg[1];
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("short flags not cleared by read");
endmodule // hvw_top
`default_nettype wire

// ---- tb/hvw_wake_bus.sv ----
// wake bus and pin load model facing the wake driver
`timescale 1ns/1ps
`default_nettype none
module hvw_wake_bus (
	// driver side
	input  wire logic wake_pin_out,
	input  wire logic wake_pin_oe,
	input  wire logic open_circuit_check_en,
	// fault and load setup from the bench
	input  wire logic bat_short,
	input  wire logic load_open,
	// comparator level
	output var  logic wake_pin_in
);
	// pin level, strongest source first; a battery short beats the pull-down
	// pin level resolution
	always_comb begin
		if (bat_short)
			wake_pin_in = 1'b1;
		else if (wake_pin_oe)
			wake_pin_in = wake_pin_out;
		else
			wake_pin_in = open_circuit_check_en & load_open;
	end
endmodule // hvw_wake_bus
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the wake pin and interrupt control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        clk, arst_n, rd_s, wr_s, wt, oe, po, oce, irq, pin;
	logic [2:0]  adr;
	logic [3:0]  be;
	logic [31:0] wd, rdat, q;
	logic        woc, loc, aoc, lrb, arb, th, dlow, ldl, adl, bat, opn, plow;
	int          n_mismatch, checked, cyc;
	// short counts keep the run brief
	hvw_top #(.XFER_CYC(8), .BUS_SC_CYC(5), .WAKE_SC_CYC(10), .MONO_CYC(20)) dut_u (
		.clk(clk), .arst_n(arst_n), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
		.avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt),
		.wake_pin_in(pin), .wake_pin_out(po), .wake_pin_oe(oe), .open_circuit_check_en(oce),
		.wake_overcurrent(woc), .lin_overcurrent(loc), .aux_overcurrent(aoc), .lin_readback(lrb),
		.aux_hv_bus_pin_readback(arb), .thermal_shutdown(th), .regulated_digital_supply_low(dlow),
		.supply_monitor_low(plow), .lin_driving_low(ldl), .aux_driving_low(adl),
		.hv_interrupt_line(irq));
	hvw_wake_bus bus_u (.wake_pin_out(po), .wake_pin_oe(oe), .open_circuit_check_en(oce),
		.bat_short(bat), .load_open(opn), .wake_pin_in(pin));
	// clock
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// hang guard, well above the total of all scenarios
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checked %0d n_mismatch %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask
	// one bus cycle, held until waitrequest is sampled low
	task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
		@(posedge clk);
		adr <= a;
		wd <= d;
		wr_s <= w;
		rd_s <= !w;
		do @(posedge clk); while (wt !== 1'b0);
		q = rdat;
		rd_s <= 1'b0;
		wr_s <= 1'b0;
	endtask
	task automatic wirq();
		for (int i = 0; i < 60 && irq !== 1'b1; i++) @(posedge clk);
		chk("irq", 32'h0000_0001, 32'(irq));
	endtask
	// handler view: poll busy, confirm ok, then fetch the snapshot
	task automatic snap(input logic [7:0] e);
		q = 32'h0000_0001;
		while (q[0] !== 1'b0) bus(0, 0, 0);
		chk("ok", 32'h0000_0001, 32'(q[1]));
		bus(0, 1, 0);
		chk("data", 32'(e), q);
	endtask
	task automatic t_reset();
		chk("oe", 0, 32'(oe));
		bus(0, 2, 0);
		chk("cfg1", 0, q);
		bus(0, 7, 0);
		chk("unmapped", 0, q);
		// a write with its byte lane off must be ignored
		be <= 4'hE;
		bus(1, 3, 32'h0000_0020);
		be <= 4'hF;
		bus(0, 3, 0);
		chk("lane off", 0, q);
		bus(1, 5, 32'h0001_0000);
	endtask
	task automatic t_mono();
		bus(1, 2, 32'h0000_0010);
		// just before the transfer ends the driver must still be off
		tick(8);
		chk("oe early", 0, 32'(oe));
		tick(6);
		chk("oe on", 32'h0000_0001, 32'(oe));
		tick(30);
		chk("oe mono", 0, 32'(oe));
		// let the off value land so the monoflop expiry is released
		bus(1, 2, 0);
		tick(14);
	endtask
	// wake short and thermal off, with the monoflop out of the way
	task automatic t_short();
		bus(1, 3, 32'h0000_0002);
		bus(1, 2, 32'h0000_0010);
		tick(50);
		chk("oe held", 32'h0000_0001, 32'(oe));
		woc <= 1'b1;
		wirq();
		bus(0, 0, 0);
		chk("busy", 32'h0000_0001, 32'(q[0]));
		woc <= 1'b0;
		snap(8'h01);
		chk("irq clr", 0, 32'(irq));
		th <= 1'b1;
		wirq();
		th <= 1'b0;
		snap(8'h08);
		chk("oe thermal", 0, 32'(oe));
		bus(0, 4, 0);
		chk("mon thermal", 32'h0000_0001, 32'(q[4]));
		bus(1, 3, 32'h0000_000A);
		tick(14);
		chk("oe again", 32'h0000_0001, 32'(oe));
		bus(1, 2, 0);
		tick(14);
	endtask
	task automatic t_bus();
		{ldl, loc, adl, aoc} <= 4'hF;
		wirq();
		{ldl, loc, adl, aoc} <= 4'h0;
		snap(8'h06);
		bus(1, 0, 32'h0000_0004);
		snap(8'h00);
		lrb <= 1'b1;
		tick(6);
		bus(0, 4, 0);
		chk("readback", 32'h0000_0004, q & 32'h0000_0006);
		{lrb, arb} <= 2'b01;
		tick(6);
		bus(0, 4, 0);
		chk("aux readback", 32'h0000_0002, q & 32'h0000_0006);
	endtask
	task automatic t_pin();
		bus(1, 3, 32'h0000_0020);
		tick(14);
		opn <= 1'b1;
		tick(6);
		bus(0, 4, 0);
		chk("open", 32'h0000_0001, 32'(q[7]));
		// load back on before io mode, so no stray pin edge is seen
		opn <= 1'b0;
		tick(6);
		bus(0, 4, 0);
		chk("loaded", 0, 32'(q[7]));
		bus(1, 3, 32'h0000_0010);
		tick(14);
		bat <= 1'b1;
		wirq();
		snap(8'h10);
		bus(0, 4, 0);
		chk("pin live", 32'h0000_0001, 32'(q[7]));
		bat <= 1'b0;
		wirq();
		snap(8'h10);
		bus(1, 3, 0);
	endtask
	task automatic t_lvf();
		bus(1, 2, 32'h0000_0004);
		tick(14);
		bus(0, 4, 0);
		chk("lvf set", 32'h0000_0001, 32'(q[3]));
		dlow <= 1'b1;
		tick(6);
		dlow <= 1'b0;
		tick(6);
		bus(0, 4, 0);
		chk("lvf low", 0, 32'(q[3]));
	endtask
	// supply monitor: live status bit, interrupt while low, enable gate
	task automatic t_psm();
		bus(1, 2, 32'h0000_0008);
		tick(14);
		plow <= 1'b1;
		wirq();
		snap(8'h20);
		bus(0, 4, 0);
		chk("psm live", 32'h0000_0001, 32'(q[5]));
		bus(1, 5, 0);
		tick(2);
		chk("irq gated", 0, 32'(irq));
		plow <= 1'b0;
		tick(6);
		bus(0, 4, 0);
		chk("psm gone", 0, 32'(q[5]));
	endtask
	// main sequence
	initial begin
		{arst_n, rd_s, wr_s, woc, loc, aoc, lrb, arb, th, dlow, ldl, adl, bat, opn, plow} = 15'h0000;
		adr = 3'h0;
		be = 4'hF;
		wd = 32'h0000_0000;
		tick(2);
		arst_n <= 1'b1;
		t_reset();
		t_mono();
		t_short();
		t_bus();
		t_pin();
		t_lvf();
		t_psm();
		complete_run();
	end
endmodule // testbench
`default_nettype wire
